// >>> verif/prot_regs_chk.sv
// Port checker for the protection debug and status register bank
`timescale 1ns/1ps
`default_nettype none
module prot_regs_chk #(
	parameter int CHAN_W = 8,
	parameter int TIMEOUT_CYCLES = 20
) (
	// Clock, reset and bus
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic [prot_regs_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic avs_waitrequest_out,
	// Link, engine and video side
	input wire logic [7:0] remote_debug_in,
	input wire logic remote_debug_load_in,
	input wire logic auth_success_in,
	input wire logic auth_lost_in,
	input wire logic auth_restart_in,
	input wire logic prot_bus_activity_in,
	input wire logic downstream_enabled_in,
	input wire logic pixel_valid_in,
	input wire logic [3*CHAN_W-1:0] decrypted_in,
	input wire logic [3*CHAN_W-1:0] encrypted_in,
	input wire logic [3*CHAN_W-1:0] rgb_out,
	input wire logic prot_bus_fast_timing_out,
	input wire logic prot_bus_free_out,
	input wire logic auth_timer_speedup_out,
	input wire logic short_verify_due_out,
	input wire logic long_verify_due_out,
	input wire logic downstream_enable_req_out
);
	logic ctl_wr, pol_ff, byp_ff, nxt_pol, nxt_byp;
	logic [3*CHAN_W-1:0] exp_rgb;
	// Shadow of the control bits, taken only from completed writes
	assign ctl_wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
		&& avs_address_in == {prot_regs_pkg::IDX_DEBUG_CONTROL, 2'h0};
	assign nxt_pol = ctl_wr ? avs_writedata_in[prot_regs_pkg::CTL_POLICY_BIT] : pol_ff;
	assign nxt_byp = ctl_wr ? avs_writedata_in[prot_regs_pkg::CTL_BYPASS_BIT] : byp_ff;
	assign exp_rgb = byp_ff ? encrypted_in : decrypted_in;
	always_ff @(posedge clock_in)
	begin
		pol_ff <= reset_in ? 1'b0 : nxt_pol;
		byp_ff <= reset_in ? 1'b0 : nxt_byp;
	end
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (reset_in);
	chk_fast_follows: assert property (remote_debug_load_in ##1 !remote_debug_load_in |=>
		prot_bus_fast_timing_out == $past(remote_debug_in[0], 2)) else $error("fast timing not mirrored");
	chk_speedup_follows: assert property (remote_debug_load_in ##1 !remote_debug_load_in |=>
		auth_timer_speedup_out == $past(remote_debug_in[1], 2)) else $error("speedup not mirrored");
	chk_timeout_off: assert property (remote_debug_load_in && remote_debug_in[6] |->
		##2 !prot_bus_free_out) else $error("bus freed with timeout off");
	chk_activity_busy: assert property (prot_bus_activity_in |-> ##2 !prot_bus_free_out)
		else $error("bus free right after activity");
	chk_reenable_req: assert property (auth_restart_in && !(pol_ff && downstream_enabled_in) |=>
		downstream_enable_req_out) else $error("no re-enable request");
	chk_skip_enabled: assert property (auth_restart_in && pol_ff && downstream_enabled_in |=>
		!downstream_enable_req_out) else $error("needless re-enable request");
	chk_bypass_select: assert property (pixel_valid_in |=> rgb_out == $past(exp_rgb))
		else $error("wrong video selected");
	chk_auth_lost: assert property ((auth_lost_in || auth_restart_in) ##1 !auth_success_in |=>
		!short_verify_due_out && !long_verify_due_out) else $error("verify after loss");
	cover property (auth_restart_in && pol_ff && downstream_enabled_in);
	cover property (pixel_valid_in && byp_ff);
	cover property ($rose(prot_bus_free_out));
endmodule : prot_regs_chk
bind content_protect_debug_status_regs prot_regs_chk #(.CHAN_W(CHAN_W), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_prot_regs_chk (
	.clock_in, .reset_in, .avs_address_in, .avs_write_in, .avs_byteenable_in, .avs_writedata_in,
	.avs_waitrequest_out, .remote_debug_in, .remote_debug_load_in, .auth_success_in, .auth_lost_in,
	.auth_restart_in, .prot_bus_activity_in, .downstream_enabled_in, .pixel_valid_in, .decrypted_in,
	.encrypted_in, .rgb_out, .prot_bus_fast_timing_out, .prot_bus_free_out, .auth_timer_speedup_out,
	.short_verify_due_out, .long_verify_due_out, .downstream_enable_req_out);
`default_nettype wire

// >>> verif/tb_content_protect_debug_status_regs.sv
// Self-checking bench for the protection debug and status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_content_protect_debug_status_regs;
	localparam int TO = 20;
	localparam logic [9:0] A_MIR = {prot_regs_pkg::IDX_DEBUG_MIRROR, 2'h0};
	localparam logic [9:0] A_CTL = {prot_regs_pkg::IDX_DEBUG_CONTROL, 2'h0};
	localparam logic [9:0] A_STS = {prot_regs_pkg::IDX_STATUS, 2'h0};
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic [9:0] avs_address_in = 10'h000;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0000_0000;
	logic [3:0] ev = 4'h0;
	logic prot_bus_activity_in = 1'b0;
	logic downstream_enabled_in = 1'b0;
	wire logic [31:0] avs_readdata_out;
	wire logic [1:0] avs_response_out;
	wire logic avs_waitrequest_out, fast_out, speed_out, free_out, sv_out, lv_out, req_out;
	wire logic [7:0] dbg;
	wire logic dbg_ld, pv, le, sv;
	wire logic [23:0] dec, enc, sum, rgb_out;
	logic [31:0] rdq;
	logic [1:0] rsp;
	logic [7:0] v;
	int seed = 8;
	int fails = 0, compares = 0, cycles = 0, shorts = 0, longs = 0, reqs = 0, r0;
	always #20 clock_in = ~clock_in;
	tx_link_model u_tx_link_model (.clock_in(clock_in), .remote_debug_out(dbg), .remote_debug_load_out(dbg_ld),
		.pixel_valid_out(pv), .decrypted_out(dec), .encrypted_out(enc), .line_end_out(le), .sum_valid_out(sv),
		.sum_out(sum));
	content_protect_debug_status_regs #(.TIMEOUT_CYCLES(TO)) u_content_protect_debug_status_regs (
		.clock_in(clock_in), .reset_in(reset_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_byteenable_in(4'hF), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.avs_response_out(avs_response_out), .remote_debug_in(dbg), .remote_debug_load_in(dbg_ld),
		.auth_success_in(ev[0]), .auth_lost_in(ev[1]), .auth_restart_in(ev[2]), .frame_start_in(ev[3]),
		.prot_bus_activity_in(prot_bus_activity_in), .downstream_enabled_in(downstream_enabled_in),
		.pixel_valid_in(pv), .decrypted_in(dec), .encrypted_in(enc), .line_end_in(le), .sum_valid_in(sv),
		.sum_in(sum), .rgb_out(rgb_out), .prot_bus_fast_timing_out(fast_out), .prot_bus_free_out(free_out),
		.auth_timer_speedup_out(speed_out), .short_verify_due_out(sv_out), .long_verify_due_out(lv_out),
		.downstream_enable_req_out(req_out));
	task automatic finish_test();
		if (fails == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
		avs_address_in <= a;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		avs_writedata_in <= d;
		@(posedge clock_in);
		while (avs_waitrequest_out !== 1'b0)
			@(posedge clock_in);
		rdq = avs_readdata_out;
		rsp = avs_response_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge clock_in);
	endtask : bus
	task automatic pulse(input logic [3:0] m);
		ev <= m;
		@(posedge clock_in);
		ev <= 4'h0;
		@(posedge clock_in);
	endtask : pulse
	function automatic logic [31:0] sts(input logic e, input logic a);
		return {30'h0000_0000, e, a};
	endfunction : sts
	always @(posedge clock_in)
	begin
		cycles++;
		shorts += sv_out;
		longs += lv_out;
		reqs += req_out;
		if (cycles == 6000)
		begin
			fails++;
			finish_test();
		end
	end
	initial
	begin
		repeat (20) @(posedge clock_in);
		reset_in <= 1'b0;
		@(posedge clock_in);
		bus(1'b0, A_CTL, 32'h0000_0000);
		`CHECK(rdq, 32'h0000_0000)
		bus(1'b0, A_STS, 32'h0000_0000);
		`CHECK(rdq, sts(1'b0, 1'b0))
		bus(1'b0, 10'h308, 32'h0000_0000);
		`CHECK({rsp, rdq}, {2'h2, 32'h0000_0000})
		for (int i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 8'hFF : 8'($random(seed));
			u_tx_link_model.load(v);
			bus(1'b1, A_MIR, ~{24'h00_0000, v});
			bus(1'b0, A_MIR, 32'h0000_0000);
			`CHECK(rdq, {24'h00_0000, v & prot_regs_pkg::MIRROR_MASK})
			`CHECK({speed_out, fast_out}, v[1:0])
		end
		u_tx_link_model.load(8'h00);
		prot_bus_activity_in <= 1'b1;
		@(posedge clock_in);
		prot_bus_activity_in <= 1'b0;
		repeat (TO - 2) @(posedge clock_in);
		`CHECK(free_out, 1'b0)
		repeat (6) @(posedge clock_in);
		`CHECK(free_out, 1'b1)
		u_tx_link_model.load(8'h40);
		repeat (TO + 4) @(posedge clock_in);
		`CHECK(free_out, 1'b0)
		for (int i = 0; i < 4; i++)
		begin
			u_tx_link_model.load({4'h0, i[1], 3'h0});
			bus(1'b1, A_CTL, {$random(seed)} & 32'hFFFF_FFFD | {30'h0000_0000, i[0], 1'b0});
			bus(1'b1, A_STS, $random(seed));
			u_tx_link_model.line(3 + i, i[0]);
			`CHECK(rgb_out, i[0] ? ~enc : ~dec)
			bus(1'b0, A_STS, 32'h0000_0000);
			`CHECK(rdq, sts(i[0] & i[1], 1'b0))
		end
		bus(1'b1, A_STS, 32'h0000_0000);
		bus(1'b0, A_STS, 32'h0000_0000);
		`CHECK(rdq, sts(1'b0, 1'b0))
		for (int f = 1; f >= 0; f--)
		begin
			u_tx_link_model.load({5'h00, f[0], 2'h0});
			pulse(4'h1);
			bus(1'b0, A_STS, 32'h0000_0000);
			`CHECK(rdq, sts(1'b0, 1'b1))
			shorts = 0;
			longs = 0;
			repeat (f ? 32 : 128) pulse(4'h8);
			repeat (2) @(posedge clock_in);
			`CHECK({shorts, longs}, f ? {32'd16, 32'd2} : {32'd8, 32'd1})
			pulse(4'h2);
			bus(1'b0, A_STS, 32'h0000_0000);
			`CHECK(rdq, sts(1'b0, 1'b0))
		end
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, A_CTL, {30'h0000_0000, 1'b0, i[0]});
			downstream_enabled_in <= i[1];
			pulse(4'h1);
			r0 = reqs;
			pulse(4'h4);
			@(posedge clock_in);
			`CHECK(reqs - r0, (i == 3) ? 0 : 1)
			bus(1'b0, A_STS, 32'h0000_0000);
			`CHECK(rdq, sts(1'b0, 1'b0))
		end
		finish_test();
	end
endmodule : tb_content_protect_debug_status_regs
`default_nettype wire

// >>> verif/tx_link_model.sv
// Far-end transmitter model: debug settings, video lines and line checksums
`timescale 1ns/1ps
`default_nettype none
module tx_link_model (
	// Clock
	input wire logic clock_in,
	// Link outputs
	output logic [7:0] remote_debug_out = 8'h00,
	output logic remote_debug_load_out = 1'b0,
	output logic pixel_valid_out = 1'b0,
	output logic [23:0] decrypted_out = 24'h00_0000,
	output logic [23:0] encrypted_out = 24'h00_0000,
	output logic line_end_out = 1'b0,
	output logic sum_valid_out = 1'b0,
	output logic [23:0] sum_out = 24'h00_0000
);
	int seed = 8;
	task automatic load(input logic [7:0] v);
		remote_debug_out <= v;
		remote_debug_load_out <= 1'b1;
		@(posedge clock_in);
		remote_debug_load_out <= 1'b0;
		remote_debug_out <= ~v;
		@(posedge clock_in);
	endtask : load
	task automatic line(input int n, input logic bad);
		logic [23:0] p;
		logic [23:0] e;
		logic [8:0] t;
		logic [7:0] s [3];
		s = '{8'h00, 8'h00, 8'h00};
		for (int k = 0; k < n; k++)
		begin
			p = 24'($random(seed));
			e = p ^ 24'h5A_C3E1;
			// Checksum covers the video as it crosses the link, still encrypted
			for (int c = 0; c < 3; c++)
			begin
				t = {1'b0, s[c]} + {1'b0, e[c*8+:8]};
				s[c] = t[7:0] + {7'h00, t[8]};
			end
			pixel_valid_out <= 1'b1;
			decrypted_out <= p;
			encrypted_out <= e;
			@(posedge clock_in);
		end
		pixel_valid_out <= 1'b0;
		decrypted_out <= ~p;
		encrypted_out <= ~(p ^ 24'h5A_C3E1);
		line_end_out <= 1'b1;
		@(posedge clock_in);
		line_end_out <= 1'b0;
		sum_valid_out <= 1'b1;
		sum_out <= ~{s[2], s[1], s[0]} ^ {23'h00_0000, bad};
		@(posedge clock_in);
		sum_valid_out <= 1'b0;
		sum_out <= {s[2], s[1], s[0]};
		@(posedge clock_in);
	endtask : line
endmodule : tx_link_model
`default_nettype wire

// >>> verilog/content_protect_debug_status_regs.sv
// Protection debug mirror, local controls and status registers on Avalon-MM
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module content_protect_debug_status_regs #(
	parameter int CHAN_W = 8,
	parameter int TIMEOUT_CYCLES = prot_regs_pkg::BUS_TIMEOUT_CYCLES
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// Avalon-MM slave
	input wire logic [prot_regs_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic [1:0] avs_response_out,
	// Remote transmitter debug settings
	input wire logic [7:0] remote_debug_in,
	input wire logic remote_debug_load_in,
	// Authentication engine
	input wire logic auth_success_in,
	input wire logic auth_lost_in,
	input wire logic auth_restart_in,
	input wire logic frame_start_in,
	// Protection bus activity
	input wire logic prot_bus_activity_in,
	// Downstream transmitter state
	input wire logic downstream_enabled_in,
	// Video
	input wire logic pixel_valid_in,
	input wire logic [3*CHAN_W-1:0] decrypted_in,
	input wire logic [3*CHAN_W-1:0] encrypted_in,
	input wire logic line_end_in,
	input wire logic sum_valid_in,
	input wire logic [3*CHAN_W-1:0] sum_in,
	// Derived controls
	output logic [3*CHAN_W-1:0] rgb_out,
	output logic prot_bus_fast_timing_out,
	output logic prot_bus_free_out,
	output logic auth_timer_speedup_out,
	output logic short_verify_due_out,
	output logic long_verify_due_out,
	output logic downstream_enable_req_out
);
	// ********************************
	// Parameter checks
	// ********************************
	// The verify schedule masks a wrapping frame count, so every
	// interval must be a power of two below the counter's span
	localparam int FRAME_CNT_W = 8;
	localparam int FRAME_CNT_SPAN = 1 << FRAME_CNT_W;

	function automatic bit is_pow2_fit(input int n);
		return n > 0 && n < FRAME_CNT_SPAN && (n & (n - 1)) == 0;
	endfunction : is_pow2_fit

	initial
	begin
		if (CHAN_W < 2)
			$error("CHAN_W must be at least two");
		if (TIMEOUT_CYCLES < 2)
			$error("TIMEOUT_CYCLES must be at least two");
		if (!is_pow2_fit(prot_regs_pkg::SHORT_VERIFY_FAST) || !is_pow2_fit(prot_regs_pkg::LONG_VERIFY_FAST))
			$error("Fast verify intervals must be powers of two");
		if (!is_pow2_fit(prot_regs_pkg::SHORT_VERIFY_SLOW) || !is_pow2_fit(prot_regs_pkg::LONG_VERIFY_SLOW))
			$error("Slow verify intervals must be powers of two");
	end

	// ********************************
	// Bus decode
	// ********************************
	logic [7:0] mirror_ff;
	logic [7:0] control_ff;
	logic chk_err_ff;
	logic auth_ff;
	logic [31:0] rdata_ff;
	logic rvalid_ff;
	logic [1:0] resp_ff;
	logic [7:0] word_idx;
	logic hit_mirror;
	logic hit_control;
	logic hit_status;
	logic hit_any;
	logic req_pending;
	logic wr_go;
	logic [7:0] status_word;
	logic [31:0] nxt_rdata;
	logic [31:0] nxt_rdata_sel;
	logic [1:0] nxt_resp;

	// Avalon response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register index from a byte address; the low two bits are dropped
	function automatic logic [7:0] reg_index(input logic [prot_regs_pkg::ADDR_W-1:0] addr);
		return addr[prot_regs_pkg::ADDR_W-1:2];
	endfunction : reg_index

	function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] target);
		return idx == target;
	endfunction : reg_hit

	// Index is byte address over four
	assign word_idx = reg_index(avs_address_in);
	assign hit_mirror = reg_hit(word_idx, prot_regs_pkg::IDX_DEBUG_MIRROR);
	assign hit_control = reg_hit(word_idx, prot_regs_pkg::IDX_DEBUG_CONTROL);
	assign hit_status = reg_hit(word_idx, prot_regs_pkg::IDX_STATUS);
	assign hit_any = hit_mirror | hit_control | hit_status;
	assign req_pending = (avs_read_in | avs_write_in) & !rvalid_ff;
	assign wr_go = avs_write_in & rvalid_ff;
	// One wait state on every access
	assign avs_waitrequest_out = req_pending;

	assign status_word = {6'b00_0000, chk_err_ff, auth_ff};
	assign nxt_rdata = hit_mirror ? {24'h00_0000, mirror_ff & prot_regs_pkg::MIRROR_MASK}
		: hit_control ? {24'h00_0000, control_ff}
		: hit_status ? {24'h00_0000, status_word}
		: 32'h0000_0000;
	assign nxt_rdata_sel = avs_read_in ? nxt_rdata : 32'h0000_0000;
	assign nxt_resp = hit_any ? RESP_OKAY : RESP_SLVERR;

	// Low again after one cycle, so a held request waits once more
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			rvalid_ff <= 1'b0;
		else
			rvalid_ff <= req_pending;
	end

	// Taken in the wait state; stands until the next access
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			rdata_ff <= 32'h0000_0000;
		else if (req_pending)
			rdata_ff <= nxt_rdata_sel;
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			resp_ff <= RESP_OKAY;
		else if (req_pending)
			resp_ff <= nxt_resp;
	end

	assign avs_readdata_out = rdata_ff;
	assign avs_response_out = resp_ff;

	// ********************************
	// Registers
	// ********************************
	logic wr_control;
	logic wr_status;
	logic chk_mismatch_evt;
	logic chk_enable;

	line_chksum_if chk_if ();

	assign wr_control = wr_go & hit_control & avs_byteenable_in[0];
	assign wr_status = wr_go & hit_status;
	assign chk_enable = mirror_ff[prot_regs_pkg::MIR_CHKSUM_EN_BIT];
	assign chk_mismatch_evt = chk_enable & chk_if.check_done & chk_if.mismatch;

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			mirror_ff <= 8'h00_00;
		else if (remote_debug_load_in)
			mirror_ff <= remote_debug_in & prot_regs_pkg::MIRROR_MASK;
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			control_ff <= prot_regs_pkg::CONTROL_RESET;
		else if (wr_control)
			control_ff <= avs_writedata_in[7:0] & prot_regs_pkg::CONTROL_MASK;
	end

	// Set wins over the clear in the same cycle
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			chk_err_ff <= 1'b0;
		else if (chk_mismatch_evt)
			chk_err_ff <= 1'b1;
		else if (wr_status)
			chk_err_ff <= 1'b0;
	end

	// Loss or restart outranks success so a stale success cannot stick
	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			auth_ff <= 1'b0;
		else if (auth_lost_in || auth_restart_in)
			auth_ff <= 1'b0;
		else if (auth_success_in)
			auth_ff <= 1'b1;
	end

	line_chksum_check #(
		.CHAN_W(CHAN_W)
	) u_chk (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.enable_in(chk_enable),
		.pixel_valid_in(pixel_valid_in),
		.pixel_in(encrypted_in),
		.line_end_in(line_end_in),
		.sum_valid_in(sum_valid_in),
		.sum_in(sum_in),
		.res(chk_if.checker_side)
	);

	// ********************************
	// Video output
	// ********************************
	logic [3*CHAN_W-1:0] rgb_ff;
	logic bypass;

	assign bypass = control_ff[prot_regs_pkg::CTL_BYPASS_BIT];

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			rgb_ff <= '0;
		else if (pixel_valid_in)
			rgb_ff <= bypass ? encrypted_in : decrypted_in;
	end
	assign rgb_out = rgb_ff;

	// ********************************
	// Protection bus timeout
	// ********************************
	logic [31:0] idle_cnt_ff;
	logic free_ff;
	logic timeout_dis;
	logic idle_restart;
	logic idle_expired;

	assign timeout_dis = mirror_ff[prot_regs_pkg::MIR_TIMEOUT_DIS_BIT];

	// Activity or a disabled timeout restarts the count and takes the bus back
	assign idle_restart = prot_bus_activity_in | timeout_dis;
	assign idle_expired = idle_cnt_ff >= 32'(TIMEOUT_CYCLES);

	// Saturates at the limit, so a long quiet spell cannot wrap it
	always_ff @(posedge clock_in)
	begin
		if (reset_in || idle_restart)
			idle_cnt_ff <= 32'h0000_0000;
		else if (!idle_expired)
			idle_cnt_ff <= idle_cnt_ff + 32'h0000_0001;
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in || idle_restart)
			free_ff <= 1'b0;
		else if (idle_expired)
			free_ff <= 1'b1;
	end
	assign prot_bus_free_out = free_ff;
	assign prot_bus_fast_timing_out = mirror_ff[prot_regs_pkg::MIR_FAST_BUS_BIT];
	assign auth_timer_speedup_out = mirror_ff[prot_regs_pkg::MIR_SPEEDUP_BIT];

	// ********************************
	// Link verification schedule
	// ********************************
	logic [7:0] frame_cnt_ff;
	logic [7:0] nxt_frame_cnt;
	logic short_hit;
	logic long_hit;
	logic [7:0] short_int;
	logic [7:0] long_int;
	logic fast_link_verify;
	logic short_ff;
	logic long_ff;

	assign fast_link_verify = mirror_ff[prot_regs_pkg::MIR_FAST_LINK_VERIFY_BIT];
	assign short_int = fast_link_verify ? 8'(prot_regs_pkg::SHORT_VERIFY_FAST) : 8'(prot_regs_pkg::SHORT_VERIFY_SLOW);
	assign long_int = fast_link_verify ? 8'(prot_regs_pkg::LONG_VERIFY_FAST) : 8'(prot_regs_pkg::LONG_VERIFY_SLOW);

	// Counter wraps at its own span; every interval divides it, so pulses stay evenly spaced
	assign nxt_frame_cnt = frame_cnt_ff + 8'h01;
	assign short_hit = frame_start_in && (nxt_frame_cnt & (short_int - 8'h01)) == 8'h00;
	assign long_hit = frame_start_in && (nxt_frame_cnt & (long_int - 8'h01)) == 8'h00;

	// Count restarts whenever authentication is not held
	always_ff @(posedge clock_in)
	begin
		if (reset_in || !auth_ff)
			frame_cnt_ff <= 8'h00;
		else if (frame_start_in)
			frame_cnt_ff <= nxt_frame_cnt;
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in || !auth_ff)
		begin
			short_ff <= 1'b0;
			long_ff <= 1'b0;
		end
		else
		begin
			short_ff <= short_hit;
			long_ff <= long_hit;
		end
	end
	assign short_verify_due_out = short_ff;
	assign long_verify_due_out = long_ff;

	// ********************************
	// Repeater re-enable
	// ********************************
	logic reen_ff;
	logic policy_skip;

	assign policy_skip = control_ff[prot_regs_pkg::CTL_POLICY_BIT];

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
			reen_ff <= 1'b0;
		else
			// Pulse at authentication restart unless policy_skip is set and downstream is already enabled
			reen_ff <= auth_restart_in & !(policy_skip & downstream_enabled_in);
	end
	assign downstream_enable_req_out = reen_ff;
endmodule : content_protect_debug_status_regs
`default_nettype wire

// >>> verilog/line_chksum_check.sv
// Per-channel ones-complement line checksum accumulator and comparator
`timescale 1ns/1ps
`default_nettype none
module line_chksum_check #(
	parameter int CHAN_W = 8
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// Video
	input wire logic enable_in,
	input wire logic pixel_valid_in,
	input wire logic [3*CHAN_W-1:0] pixel_in,
	input wire logic line_end_in,
	input wire logic sum_valid_in,
	input wire logic [3*CHAN_W-1:0] sum_in,
	// Result
	line_chksum_if.checker_side res
);
	initial
	begin
		if (CHAN_W < 1)
			$error("CHAN_W must be positive");
	end

	logic [3*CHAN_W-1:0] acc_ff;
	logic [3*CHAN_W-1:0] nxt_acc;
	logic waiting_ff;
	logic done_ff;
	logic mism_ff;
	logic [2:0] ch_bad;

	// Ones-complement addition with end-around carry
	function automatic logic [CHAN_W-1:0] oc_add(input logic [CHAN_W-1:0] a, input logic [CHAN_W-1:0] b);
		logic [CHAN_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		oc_add = s[CHAN_W-1:0] + {{(CHAN_W-1){1'b0}}, s[CHAN_W]};
	endfunction : oc_add

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_chan
			assign nxt_acc[g*CHAN_W +: CHAN_W] = oc_add(acc_ff[g*CHAN_W +: CHAN_W], pixel_in[g*CHAN_W +: CHAN_W]);
			// Sent value is the complement of the sum
			assign ch_bad[g] = (~acc_ff[g*CHAN_W +: CHAN_W]) != sum_in[g*CHAN_W +: CHAN_W];
		end
	endgenerate

	always_ff @(posedge clock_in)
	begin
		if (reset_in || !enable_in)
		begin
			acc_ff <= '0;
			waiting_ff <= 1'b0;
			done_ff <= 1'b0;
			mism_ff <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			mism_ff <= 1'b0;
			if (waiting_ff && sum_valid_in)
			begin
				// Receive trailing checksum after the line
				done_ff <= 1'b1;
				mism_ff <= |ch_bad;
				waiting_ff <= 1'b0;
				acc_ff <= '0;
			end
			else if (pixel_valid_in && !waiting_ff)
				acc_ff <= nxt_acc;
			if (line_end_in)
				waiting_ff <= 1'b1;
		end
	end

	assign res.check_done = done_ff;
	assign res.mismatch = mism_ff;
endmodule : line_chksum_check
`default_nettype wire

// >>> verilog/line_chksum_if.sv
// Interface carrying line checksum results between the checker and the register bank
`timescale 1ns/1ps
`default_nettype none
interface line_chksum_if;
	logic check_done;
	logic mismatch;
	modport checker_side (output check_done, output mismatch);
	modport bank_side (input check_done, input mismatch);
endinterface : line_chksum_if
`default_nettype wire

// >>> verilog/prot_regs_pkg.sv
// Package of offsets, fields and timing constants for the protection debug/status registers
package prot_regs_pkg;
	// ********************************
	// Register map
	// ********************************
	// Printed offsets are not all multiples of four, so they are indices
	localparam logic [7:0] IDX_DEBUG_MIRROR = 8'h00_C0;
	localparam logic [7:0] IDX_DEBUG_CONTROL = 8'h00_C1;
	localparam logic [7:0] IDX_STATUS = 8'h00_C4;
	localparam int ADDR_W = 10;
	// ********************************
	// Field positions
	// ********************************
	localparam int MIR_TIMEOUT_DIS_BIT = 6;
	localparam int MIR_CHKSUM_EN_BIT = 3;
	localparam int MIR_FAST_LINK_VERIFY_BIT = 2;
	localparam int MIR_SPEEDUP_BIT = 1;
	localparam int MIR_FAST_BUS_BIT = 0;
	localparam int CTL_BYPASS_BIT = 1;
	localparam int CTL_POLICY_BIT = 0;
	localparam int STS_CHKSUM_ERR_BIT = 1;
	localparam int STS_AUTH_BIT = 0;
	localparam logic [7:0] MIRROR_MASK = 8'h00_4F;
	localparam logic [7:0] CONTROL_MASK = 8'h00_03;
	localparam logic [7:0] CONTROL_RESET = 8'h00_00;
	// ********************************
	// Timing and intervals
	// ********************************
	localparam int CLOCK_HZ = 25_000_000;
	localparam int BUS_TIMEOUT_MS = 1000;
	localparam int BUS_TIMEOUT_CYCLES = (CLOCK_HZ / 1000) * BUS_TIMEOUT_MS;
	localparam int SHORT_VERIFY_FAST = 2;
	localparam int LONG_VERIFY_FAST = 16;
	localparam int SHORT_VERIFY_SLOW = 16;
	localparam int LONG_VERIFY_SLOW = 128;
	localparam int SPEEDUP_SHIFT = 4;
endpackage : prot_regs_pkg
